// File: logic/cm_modulo_agu.sv
// The address map and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ns
module cm_modulo_agu
  import cm_pkg::*;
#(
  parameter int DATA_W = 16
)
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [1:0] hresp,
  output logic [31:0] hrdata,
  // Pointer accesses from the datapath: X read, X write, Y
  input wire logic [CM_NUM_CH-1:0] agu_req,
  input wire logic [CM_NUM_CH-1:0] agu_prog_space,
  input wire logic [CM_NUM_CH*4-1:0] agu_wreg,
  input wire logic [CM_NUM_CH*DATA_W-1:0] agu_ptr,
  input wire logic [CM_NUM_CH*DATA_W-1:0] agu_step,
  // Results, one cycle after the request
  output logic [CM_NUM_CH-1:0] agu_valid,
  output logic [CM_NUM_CH-1:0] agu_wrapped,
  output logic [CM_NUM_CH-1:0] agu_prog_out,
  output logic [CM_NUM_CH*DATA_W-1:0] agu_ea,
  output logic [CM_NUM_CH*DATA_W-1:0] agu_next_ptr
);
  import cm_pkg::*;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] x_start_q, x_start_d;
  logic [DATA_W-1:0] x_end_q, x_end_d;
  logic [DATA_W-1:0] y_start_q, y_start_d;
  logic [DATA_W-1:0] y_end_q, y_end_d;
  logic [DATA_W-1:0] ctrl_q, ctrl_d;
  logic [CM_ADDR_BITS-1:0] dph_addr_q, dph_addr_d;
  logic dph_wr_q, dph_wr_d;
  logic [31:0] rdata_q, rdata_d;
  logic addr_phase;

  // Zero wait states: every transfer completes in its first data cycle
  assign hreadyout = 1'b1;
  assign hresp = CM_HRESP_OKAY;
  assign addr_phase = hsel && hready && (htrans == CM_HTRANS_NONSEQ);

  // ----------------------------------------------------------------
  // Data phase tracking
  // ----------------------------------------------------------------
  // Upper address bits are not decoded, so the map repeats every 256 bytes;
  // hsize is not checked and every access is taken as a whole word
  always_comb
  begin
    dph_addr_d = dph_addr_q;
    dph_wr_d = 1'b0;
    if (addr_phase)
    begin
      dph_addr_d = haddr[CM_ADDR_BITS-1:0];
      dph_wr_d = hwrite;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Only the low DATA_W bits of a write are kept; the rest read back 0
  // Writes land at the end of the data phase; unmapped offsets ignored
  always_comb
  begin
    x_start_d = x_start_q;
    x_end_d = x_end_q;
    y_start_d = y_start_q;
    y_end_d = y_end_q;
    ctrl_d = ctrl_q;
    if (dph_wr_q)
    begin
      unique case (dph_addr_q)
        CM_OFS_X_START: x_start_d = hwdata[DATA_W-1:0];
        CM_OFS_X_END: x_end_d = hwdata[DATA_W-1:0];
        CM_OFS_Y_START: y_start_d = hwdata[DATA_W-1:0];
        CM_OFS_Y_END: y_end_d = hwdata[DATA_W-1:0];
        // Control bits outside the fields are stored and read back unused
        CM_OFS_CONTROL: ctrl_d = hwdata[DATA_W-1:0];
        default: ctrl_d = ctrl_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Read data is taken at the address edge from the next-state values, so
  // a read right behind a write to the same register returns the new word
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (addr_phase && !hwrite)
    begin
      unique case (haddr[CM_ADDR_BITS-1:0])
        CM_OFS_X_START: rdata_d = 32'(x_start_d);
        CM_OFS_X_END: rdata_d = 32'(x_end_d);
        CM_OFS_Y_START: rdata_d = 32'(y_start_d);
        CM_OFS_Y_END: rdata_d = 32'(y_end_d);
        CM_OFS_CONTROL: rdata_d = 32'(ctrl_d);
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------
  // Bounds and control reset to zero; with both enable bits clear no window is live until software sets one up
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      x_start_q <= CM_RST_BOUND;
      x_end_q <= CM_RST_BOUND;
      y_start_q <= CM_RST_BOUND;
      y_end_q <= CM_RST_BOUND;
      ctrl_q <= CM_RST_CONTROL;
      dph_addr_q <= 8'h00;
      dph_wr_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      x_start_q <= x_start_d;
      x_end_q <= x_end_d;
      y_start_q <= y_start_d;
      y_end_q <= y_end_d;
      ctrl_q <= ctrl_d;
      dph_addr_q <= dph_addr_d;
      dph_wr_q <= dph_wr_d;
      rdata_q <= rdata_d;
    end
  end

  assign hrdata = rdata_q;

  // ----------------------------------------------------------------
  // Space enables
  // ----------------------------------------------------------------
  logic [CM_SEL_W-1:0] x_sel;
  logic [CM_SEL_W-1:0] y_sel;
  logic x_active;
  logic y_active;

  assign x_sel = ctrl_q[CM_X_SEL_LSB +: CM_SEL_W];
  assign y_sel = ctrl_q[CM_Y_SEL_LSB +: CM_SEL_W];
  // One shared window per space, so both X generators see the same buffer
  assign x_active = (x_sel != CM_SEL_OFF) && ctrl_q[CM_X_EN_BIT];
  // Select 15 parks a space even while its enable bit is set
  assign y_active = (y_sel != CM_SEL_OFF) && ctrl_q[CM_Y_EN_BIT];

  // ----------------------------------------------------------------
  // Buffer windows
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] y_lo;
  logic [DATA_W:0] x_len, y_len;
  logic x_pow2, y_pow2;

  // Y data is word sized, so its window opens on an even address
  assign y_lo = {y_start_q[DATA_W-1:1], 1'b0};
  // Length follows from the bounds, up to 64 Kbytes; seventeen bits keep a
  // full 64K window from folding to zero. An end below the start is not
  // caught: software must keep the bounds in order.
  assign x_len = {1'b0, x_end_q} - {1'b0, x_start_q} + {{DATA_W{1'b0}}, 1'b1};
  assign y_len = {1'b0, y_end_q} - {1'b0, y_lo} + {{DATA_W{1'b0}}, 1'b1};
  assign x_pow2 = (x_len & (x_len - {{DATA_W{1'b0}}, 1'b1})) == '0;
  assign y_pow2 = (y_len & (y_len - {{DATA_W{1'b0}}, 1'b1})) == '0;

  // ----------------------------------------------------------------
  // Address generators
  // ----------------------------------------------------------------
  logic [CM_NUM_CH-1:0] valid_q, valid_d;
  logic [CM_NUM_CH-1:0] wrap_q, wrap_d;
  logic [CM_NUM_CH-1:0] prog_q, prog_d;
  logic [CM_NUM_CH*DATA_W-1:0] ea_q, ea_d;
  logic [CM_NUM_CH*DATA_W-1:0] nptr_q, nptr_d;

  genvar g;
  generate
    for (g = 0; g < CM_NUM_CH; g++)
    begin : gen_ch
      localparam bit IS_Y = (g == CM_CH_Y);
      logic [DATA_W-1:0] lo, hi, ptr, step;
      logic [CM_SEL_W-1:0] sel;
      logic act, pow2, hit, inc, over, under;
      logic chk_hi, chk_lo;
      logic signed [DATA_W+1:0] sum;

      always_comb
      begin
        // Both X generators share one window, Y has its own
        lo = IS_Y ? y_lo : x_start_q;
        hi = IS_Y ? y_end_q : x_end_q;
        sel = IS_Y ? y_sel : x_sel;
        act = IS_Y ? y_active : x_active;
        pow2 = IS_Y ? y_pow2 : x_pow2;
        ptr = agu_ptr[g*DATA_W +: DATA_W];
        step = agu_step[g*DATA_W +: DATA_W];
        if (IS_Y)
          ptr[0] = 1'b0;
        // A zero step counts as incrementing
        inc = !step[DATA_W-1];
        // Two guard bits keep a step across 0x0000 or 0xffff in order
        sum = $signed({2'b00, ptr}) + $signed({{2{step[DATA_W-1]}}, step});
        over = sum > $signed({2'b00, hi});
        under = sum < $signed({2'b00, lo});
        // Only pow2 windows may be walked both ways; any other window
        // is checked only at the bound that the step heads for
        chk_hi = inc || pow2;
        chk_lo = !inc || pow2;
        // Program-space pointers take the same path as data pointers
        hit = agu_req[g] && act && (agu_wreg[g*CM_SEL_W +: CM_SEL_W] == sel);
        ea_d[g*DATA_W +: DATA_W] = ptr;
        nptr_d[g*DATA_W +: DATA_W] = sum[DATA_W-1:0];
        wrap_d[g] = 1'b0;
        valid_d[g] = agu_req[g];
        prog_d[g] = agu_prog_space[g];
        if (hit)
        begin
          // Reload the bound itself; no overshoot is carried over
          if (over && chk_hi)
          begin
            nptr_d[g*DATA_W +: DATA_W] = lo;
            wrap_d[g] = 1'b1;
          end
          else if (under && chk_lo)
          begin
            nptr_d[g*DATA_W +: DATA_W] = hi;
            if (IS_Y)
              nptr_d[g*DATA_W] = 1'b0;
            wrap_d[g] = 1'b1;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Result registers
  // ----------------------------------------------------------------
  // Results stand for one cycle; a held request simply repeats them
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      valid_q <= '0;
      wrap_q <= '0;
      prog_q <= '0;
      ea_q <= '0;
      nptr_q <= '0;
    end
    else
    begin
      valid_q <= valid_d;
      wrap_q <= wrap_d;
      prog_q <= prog_d;
      ea_q <= ea_d;
      nptr_q <= nptr_d;
    end
  end

  // ----------------------------------------------------------------
  // Result ports
  // ----------------------------------------------------------------
  // Every result is a flop, so the datapath sees no path through this block
  assign agu_valid = valid_q;
  assign agu_wrapped = wrap_q;
  assign agu_prog_out = prog_q;
  assign agu_ea = ea_q;
  assign agu_next_ptr = nptr_q;
endmodule

// File: logic/cm_pkg.sv
package cm_pkg;
  // ----------------------------------------------------------------
  // Register map (byte offsets, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] CM_OFS_X_START = 8'h00;
  localparam logic [7:0] CM_OFS_X_END = 8'h04;
  localparam logic [7:0] CM_OFS_Y_START = 8'h08;
  localparam logic [7:0] CM_OFS_Y_END = 8'h0c;
  localparam logic [7:0] CM_OFS_CONTROL = 8'h10;
  localparam int CM_ADDR_BITS = 8;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CM_X_SEL_LSB = 0;
  localparam int CM_Y_SEL_LSB = 4;
  localparam int CM_SEL_W = 4;
  localparam int CM_Y_EN_BIT = 14;
  localparam int CM_X_EN_BIT = 15;
  localparam logic [3:0] CM_SEL_OFF = 4'hf;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] CM_RST_BOUND = 16'h0000;
  localparam logic [15:0] CM_RST_CONTROL = 16'h0000;

  // ----------------------------------------------------------------
  // Address generator channels
  // ----------------------------------------------------------------
  localparam int CM_CH_X_READ = 0;
  localparam int CM_CH_X_WRITE = 1;
  localparam int CM_CH_Y = 2;
  localparam int CM_NUM_CH = 3;

  localparam logic [1:0] CM_HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] CM_HRESP_OKAY = 2'b00;
endpackage

// File: dv/cm_modulo_agu_sva.sv
`timescale 1ns/1ns
module cm_modulo_agu_chk (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Watched ports
  input wire logic hreadyout,
  input wire logic [2:0] agu_req,
  input wire logic [2:0] agu_prog_space,
  input wire logic [47:0] agu_ptr,
  input wire logic [47:0] agu_step,
  input wire logic [2:0] agu_valid,
  input wire logic [2:0] agu_wrapped,
  input wire logic [2:0] agu_prog_out,
  input wire logic [47:0] agu_ea,
  input wire logic [47:0] agu_next_ptr
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_xread_answers: assert property (agu_req[0] |=> agu_valid[0])
    else $error("x read lost");
  a_xwrite_answers: assert property (agu_req[1] |=> agu_valid[1])
    else $error("x write lost");
  a_y_no_spurious: assert property (!agu_req[2] |=> !agu_valid[2])
    else $error("y spurious");
  a_y_word_ea: assert property (agu_valid[2] |-> !agu_ea[32])
    else $error("y ea odd");
  a_prog_passes: assert property (agu_req[0] |=>
    agu_prog_out[0] == $past(agu_prog_space[0]))
    else $error("prog flag");
  a_x_ea_ptr: assert property (agu_req[0] |=>
    agu_ea[15:0] == $past(agu_ptr[15:0]))
    else $error("x ea");
  a_plain_step: assert property (agu_valid[1] && !agu_wrapped[1] |->
    agu_next_ptr[31:16] == $past(agu_ptr[31:16]) + $past(agu_step[31:16]))
    else $error("step sum");
  a_bus_ready: assert property (hreadyout)
    else $error("wait state");
endmodule
bind cm_modulo_agu cm_modulo_agu_chk u_chk (.hclk(hclk), .hresetn(hresetn),
  .hreadyout(hreadyout), .agu_req(agu_req), .agu_prog_space(agu_prog_space),
  .agu_ptr(agu_ptr), .agu_step(agu_step), .agu_valid(agu_valid),
  .agu_wrapped(agu_wrapped), .agu_prog_out(agu_prog_out), .agu_ea(agu_ea),
  .agu_next_ptr(agu_next_ptr));

// File: dv/cm_cpu_model.sv
`timescale 1ns/1ns
module cm_cpu_model (
  // Clock
  input wire logic hclk,
  // Pointer accesses
  output logic [2:0] req,
  output logic [2:0] prog,
  output logic [11:0] wreg,
  output logic [47:0] ptr,
  output logic [47:0] step
);
  initial
  begin
    req = 3'h0;
    prog = 3'h0;
    wreg = 12'h0;
    ptr = 48'h0;
    step = 48'h0;
  end
  task automatic acc(input int c, input logic [3:0] w,
    input logic [15:0] p, s, input logic pg);
    @(posedge hclk);
    req[c] <= 1'b1;
    prog[c] <= pg;
    wreg[c*4+:4] <= w;
    ptr[c*16+:16] <= p;
    step[c*16+:16] <= s;
    @(posedge hclk);
    req[c] <= 1'b0;
    // Released pointer must not look valid
    ptr[c*16+:16] <= ~p;
  endtask
endmodule

// File: dv/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import cm_pkg::*;
  logic hclk, hresetn, hwrite, rdy;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, rsp;
  logic [2:0] req, prog, vld, wrp, pgo;
  logic [11:0] wreg;
  logic [47:0] ptr, step, ea, nxt;
  int fail_count, samples_checked;
  cm_cpu_model u_cpu (.hclk(hclk), .req(req), .prog(prog), .wreg(wreg),
    .ptr(ptr), .step(step));
  cm_modulo_agu u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(rdy), .hreadyout(rdy), .hresp(rsp), .hrdata(hrdata),
    .agu_req(req), .agu_prog_space(prog), .agu_wreg(wreg), .agu_ptr(ptr),
    .agu_step(step), .agu_valid(vld), .agu_wrapped(wrp), .agu_prog_out(pgo),
    .agu_ea(ea), .agu_next_ptr(nxt));
  task automatic chk(input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    htrans <= CM_HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (rdy !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (rdy !== 1'b1);
    r = hrdata;
    chk(32'(rsp), 32'(CM_HRESP_OKAY));
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  task automatic ac(input int c, input logic [3:0] w,
    input logic [15:0] p, s, e, input logic x);
    u_cpu.acc(c, w, p, s, w[0]);
    #1;
    chk(vld[c], 1'b1);
    chk(wrp[c], x);
    chk(pgo[c], w[0]);
    chk(nxt[c*16+:16], e);
    chk(ea[c*16+:16], c == 2 ? p & 16'hfffe : p);
  endtask
  task automatic t_regs;
    logic [31:0] d;
    for (int i = 0; i < 5; i++)
    begin
      d = 32'hffff0101 + i * 32'h1111;
      rd(8'(i * 4), 32'h0);
      wr(8'(i * 4), d);
      rd(8'(i * 4), {16'h0, d[15:0]});
    end
    rd(8'h14, 32'h0);
  endtask
  task automatic t_x;
    wr(CM_OFS_X_START, 32'h1100);
    wr(CM_OFS_X_END, 32'h1163);
    wr(CM_OFS_CONTROL, 32'h8001);
    ac(0, 4'h1, 16'h1162, 16'h2, 16'h1100, 1'b1);
    ac(1, 4'h1, 16'h1100, 16'hfffe, 16'h1163, 1'b1);
    ac(0, 4'h1, 16'h1110, 16'h2, 16'h1112, 1'b0);
    ac(1, 4'h1, 16'h1170, 16'hfffe, 16'h116e, 1'b0);
    ac(0, 4'h2, 16'h1162, 16'h2, 16'h1164, 1'b0);
    wr(CM_OFS_CONTROL, 32'h800f);
    ac(0, 4'hf, 16'h1162, 16'h2, 16'h1164, 1'b0);
    ac(1, 4'hf, 16'h1162, 16'h2, 16'h1164, 1'b0);
    wr(CM_OFS_CONTROL, 32'h0001);
    ac(1, 4'h1, 16'h1162, 16'h2, 16'h1164, 1'b0);
  endtask
  task automatic t_y;
    wr(CM_OFS_Y_START, 32'h2000);
    wr(CM_OFS_Y_END, 32'h201f);
    wr(CM_OFS_CONTROL, 32'h4010);
    ac(2, 4'h1, 16'h201e, 16'h2, 16'h2000, 1'b1);
    ac(2, 4'h1, 16'h2000, 16'hfffe, 16'h201e, 1'b1);
    ac(2, 4'h1, 16'h2005, 16'h2, 16'h2006, 1'b0);
    ac(2, 4'h1, 16'h2030, 16'hfffe, 16'h2000, 1'b1);
    ac(2, 4'h0, 16'h201e, 16'h2, 16'h2020, 1'b0);
    wr(CM_OFS_CONTROL, 32'h40f0);
    ac(2, 4'hf, 16'h201e, 16'h2, 16'h2020, 1'b0);
    wr(CM_OFS_CONTROL, 32'h0010);
    ac(2, 4'h1, 16'h201e, 16'h2, 16'h2020, 1'b0);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  initial
  begin
    // Whole run needs about 115 cycles
    #20000;
    fail_count++;
    test_done();
  end
  initial
  begin
    hresetn = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_x();
    t_y();
    test_done();
  end
endmodule
